// ==== hw/dbsm_defines.vh ====
`ifndef DBSM_DEFINES_VH
`define DBSM_DEFINES_VH

// ****************************************
// Size codes
// ****************************************
`define DBSM_SIZE_BYTE 2'h1
`define DBSM_SIZE_WORD 2'h2
`define DBSM_SIZE_THREE 2'h3
`define DBSM_SIZE_LONG 2'h0

// ****************************************
// Acknowledge codes {high, low}
// ****************************************
`define DBSM_ACK_WAIT 2'h3
`define DBSM_ACK_PORT8 2'h2
`define DBSM_ACK_PORT16 2'h1
`define DBSM_ACK_RSVD 2'h0

// ****************************************
// Widths and field positions
// ****************************************
`define DBSM_ADDR_W 24
`define DBSM_DATA_W 16
`define DBSM_OP_W 32
`define DBSM_FIFO_DEPTH 16
`define DBSM_LANE_HI 15:8
`define DBSM_LANE_LO 7:0
`define DBSM_ADDR_LSB 0

`endif

// ==== hw/dbsm_fifo.v ====
`timescale 1ns/1ps
`include "dbsm_defines.vh"

module dbsm_fifo #(
    parameter WIDTH = 34,
    parameter DEPTH = `DBSM_FIFO_DEPTH,
    parameter AW = 4
) (
    input wire clock,
    input wire reset_n,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW-1:0] wr_q;
    reg [AW-1:0] rd_q;
    reg [AW:0] cnt_q;
    wire push;
    wire pop;

    assign in_ready = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign out_data = mem_q[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // ****************************************
    // Pointers and storage
    // ****************************************
    always @(posedge clock) begin
        if (!reset_n) begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end

    always @(posedge clock) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end
endmodule // dbsm_fifo

// ==== hw/dbsm_sizer.v ====
`timescale 1ns/1ps
`include "dbsm_defines.vh"


module dbsm_sizer #(
    parameter AW = `DBSM_ADDR_W,
    parameter FIFO_DEPTH = `DBSM_FIFO_DEPTH
) (
    input wire clock,
    input wire reset_n,
    input wire req_valid,
    output wire req_ready,
    input wire req_write,
    input wire [1:0] req_size,
    input wire [AW-1:0] req_addr,
    input wire [31:0] req_wdata,
    output wire rsp_valid,
    input wire rsp_ready,
    output wire [31:0] rsp_rdata,
    output wire rsp_error,
    output reg bus_cycle,
    output reg bus_write,
    output reg xfer_size_high,
    output reg xfer_size_low,
    output reg [AW-1:0] bus_addr,
    output reg [15:0] data_out,
    output reg data_oe_n,
    input wire [15:0] data_in,
    input wire size_ack_high,
    input wire size_ack_low
);
    localparam ST_IDLE = 2'h0;
    localparam ST_CYCLE = 2'h1;
    localparam ST_DONE = 2'h2;
    localparam ST_GAP = 2'h3;
    // Buffer entry: write flag, size, full address, operand
    localparam CMD_W = AW + `DBSM_OP_W + 3;
    localparam CMD_ADDR = `DBSM_OP_W;
    localparam CMD_SIZE = `DBSM_OP_W + AW;
    localparam CMD_WRITE = `DBSM_OP_W + AW + 2;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    reg [1:0] ack_s1_q;
    reg [1:0] ack_s2_q;
    reg [15:0] din_s1_q;
    reg [15:0] din_s2_q;

    always @(posedge clock) begin
        if (!reset_n) begin
            ack_s1_q <= `DBSM_ACK_WAIT;
            ack_s2_q <= `DBSM_ACK_WAIT;
            din_s1_q <= 16'h0000;
            din_s2_q <= 16'h0000;
        end else begin
            ack_s1_q <= {size_ack_high, size_ack_low};
            ack_s2_q <= ack_s1_q;
            din_s1_q <= data_in;
            din_s2_q <= din_s1_q;
        end
    end

    // ****************************************
    // Request buffer
    // ****************************************
    wire cmd_valid;
    reg cmd_ready;
    wire [CMD_W-1:0] cmd_data;
    wire cmd_write;
    wire [1:0] cmd_size;
    wire [AW-1:0] cmd_addr;
    wire [31:0] cmd_wdata;
    wire [31:0] cmd_just;
    wire [15:0] cmd_lanes;
    wire cmd_bad;

    // Whole address queued, so entries may target different ports
    dbsm_fifo #(
        .WIDTH(CMD_W),
        .DEPTH(FIFO_DEPTH),
        .AW($clog2(FIFO_DEPTH))
    ) i_dbsm_fifo (
        .clock(clock),
        .reset_n(reset_n),
        .in_valid(req_valid),
        .in_ready(req_ready),
        .in_data({req_write, req_size, req_addr, req_wdata}),
        .out_valid(cmd_valid),
        .out_ready(cmd_ready),
        .out_data(cmd_data)
    );

    // Bytes left, from size code
    function [2:0] size_bytes;
        input [1:0] code;
        begin
            case (code)
                `DBSM_SIZE_BYTE: size_bytes = 3'h1;
                `DBSM_SIZE_WORD: size_bytes = 3'h2;
                `DBSM_SIZE_THREE: size_bytes = 3'h3;
                default: size_bytes = 3'h4;
            endcase
        end
    endfunction

    // Size code from bytes left
    function [1:0] bytes_size;
        input [2:0] n;
        begin
            case (n)
                3'h1: bytes_size = `DBSM_SIZE_BYTE;
                3'h2: bytes_size = `DBSM_SIZE_WORD;
                3'h3: bytes_size = `DBSM_SIZE_THREE;
                default: bytes_size = `DBSM_SIZE_LONG;
            endcase
        end
    endfunction

    // ****************************************
    // Operand and lane helpers
    // ****************************************
    // Operand left-justified, byte 0 at the top
    function [31:0] justify;
        input [1:0] code;
        input [31:0] value;
        begin
            case (code)
                `DBSM_SIZE_BYTE: justify = {value[7:0], 24'h00_0000};
                `DBSM_SIZE_WORD: justify = {value[15:0], 16'h0000};
                `DBSM_SIZE_THREE: justify = {value[23:0], 8'h00};
                default: justify = value;
            endcase
        end
    endfunction

    // Write lanes; a lone or odd byte goes on both halves
    function [15:0] lanes;
        input [31:0] value;
        input [2:0] left;
        input lsb;
        begin
            if (left == 3'h1 || lsb) begin
                lanes = {value[31:24], value[31:24]};
            end else begin
                lanes = value[31:16];
            end
        end
    endfunction

    // ****************************************
    // Command fields
    // ****************************************
    assign cmd_write = cmd_data[CMD_WRITE];
    assign cmd_size = cmd_data[CMD_WRITE-1:CMD_SIZE];
    assign cmd_addr = cmd_data[CMD_SIZE-1:CMD_ADDR];
    assign cmd_wdata = cmd_data[CMD_ADDR-1:0];
    // Three-byte code is only a step inside a long word
    assign cmd_bad = (cmd_addr[`DBSM_ADDR_LSB] && cmd_size != `DBSM_SIZE_BYTE)
        || cmd_size == `DBSM_SIZE_THREE;
    assign cmd_just = justify(cmd_size, cmd_wdata);
    assign cmd_lanes = lanes(cmd_just, size_bytes(cmd_size), cmd_addr[`DBSM_ADDR_LSB]);

    // ****************************************
    // Sequencer
    // ****************************************
    reg [1:0] state_q;
    reg [2:0] left_q;
    reg [31:0] shift_q;
    reg [31:0] rdata_q;
    reg err_q;
    reg addr_lsb;
    wire [1:0] ack_code;
    wire ack_done;
    wire port8;
    wire [2:0] moved;
    wire [2:0] left_next;

    assign ack_code = ack_s2_q;
    // Reserved code treated like waiting; a slave must never give it
    assign ack_done = (ack_code == `DBSM_ACK_PORT8) || (ack_code == `DBSM_ACK_PORT16);
    assign port8 = (ack_code == `DBSM_ACK_PORT8);
    // Lone or odd byte or 8-bit port moves one byte, else an aligned word
    assign moved = (port8 || left_q == 3'h1 || bus_addr[`DBSM_ADDR_LSB]) ? 3'h1 : 3'h2;
    assign left_next = left_q - moved;
    assign rsp_valid = (state_q == ST_DONE);
    assign rsp_rdata = rdata_q;
    assign rsp_error = err_q;

    always @* begin
        addr_lsb = bus_addr[`DBSM_ADDR_LSB];
        // Last part's acknowledge must clear before a new operand starts
        cmd_ready = (state_q == ST_IDLE) && !ack_done;
    end

    always @(posedge clock) begin
        if (!reset_n) begin
            state_q <= ST_IDLE;
            left_q <= 3'h0;
            shift_q <= 32'h0000_0000;
            rdata_q <= 32'h0000_0000;
            err_q <= 1'b0;
            bus_cycle <= 1'b0;
            bus_write <= 1'b0;
            xfer_size_high <= 1'b0;
            xfer_size_low <= 1'b0;
            bus_addr <= {AW{1'b0}};
            data_out <= 16'h0000;
            data_oe_n <= 1'b1;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (cmd_valid && cmd_ready) begin
                        err_q <= 1'b0;
                        rdata_q <= 32'h0000_0000;
                        bus_write <= cmd_write;
                        if (cmd_bad) begin
                            err_q <= 1'b1;
                            state_q <= ST_DONE;
                        end else begin
                            left_q <= size_bytes(cmd_size);
                            shift_q <= cmd_just;
                            {xfer_size_high, xfer_size_low} <= cmd_size;
                            bus_addr <= cmd_addr;
                            // Lanes launch with the address, never an edge late
                            data_out <= cmd_lanes;
                            data_oe_n <= !cmd_write;
                            bus_cycle <= 1'b1;
                            state_q <= ST_CYCLE;
                        end
                    end
                end
                ST_CYCLE: begin
                    if (ack_done) begin
                        if (!bus_write) begin
                            // Only operand lanes kept
                            if (moved == 3'h2) begin
                                rdata_q <= {rdata_q[15:0], din_s2_q};
                            end else if (addr_lsb && !port8) begin
                                rdata_q <= {rdata_q[23:0], din_s2_q[`DBSM_LANE_LO]};
                            end else begin
                                rdata_q <= {rdata_q[23:0], din_s2_q[`DBSM_LANE_HI]};
                            end
                        end
                        shift_q <= (moved == 3'h2) ? {shift_q[15:0], 16'h0000}
                                                   : {shift_q[23:0], 8'h00};
                        bus_addr <= bus_addr + {{(AW-3){1'b0}}, moved};
                        left_q <= left_next;
                        {xfer_size_high, xfer_size_low} <= bytes_size(left_next);
                        bus_cycle <= 1'b0;
                        data_oe_n <= 1'b1;
                        if (left_next == 3'h0) begin
                            state_q <= ST_DONE;
                        end else begin
                            state_q <= ST_GAP;
                        end
                    end
                end
                ST_GAP: begin
                    // Idle until the synchronised acknowledge is seen back at the wait code
                    if (ack_code == `DBSM_ACK_WAIT) begin
                        data_out <= lanes(shift_q, left_q, addr_lsb);
                        data_oe_n <= !bus_write;
                        bus_cycle <= 1'b1;
                        state_q <= ST_CYCLE;
                    end
                end
                ST_DONE: begin
                    if (rsp_ready) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

endmodule // dbsm_sizer

// ==== tb/dbsm_sizer_props.sv ====
`timescale 1ns/1ps
module dbsm_sizer_props #(parameter AW = 24) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic rsp_valid,
    input wire logic rsp_error,
    input wire logic bus_cycle,
    input wire logic bus_write,
    input wire logic xfer_size_high,
    input wire logic xfer_size_low,
    input wire logic [AW-1:0] bus_addr,
    input wire logic [15:0] data_out,
    input wire logic data_oe_n,
    input wire logic size_ack_high,
    input wire logic size_ack_low
);
    // ****************************************
    // Bus cycle checks
    // ****************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    wire [1:0] sz = {xfer_size_high, xfer_size_low};
    wire [1:0] ak = {size_ack_high, size_ack_low};
    // Three samples cover the two-flop pin synchroniser
    chk_wait_holds: assert property ((bus_cycle && ak == 2'h3) [*3] |=> bus_cycle)
        else $error("bus cycle ended during wait");
    chk_ack_ends: assert property ((bus_cycle && (ak == 2'h1 || ak == 2'h2)) [*2]
        |-> ##[0:4] !bus_cycle) else $error("acknowledge did not end cycle");
    chk_three_odd: assert property (bus_cycle && sz == 2'h3 |-> bus_addr[0])
        else $error("three byte code at even address");
    chk_odd_narrow: assert property (bus_cycle && bus_addr[0] |-> sz[0])
        else $error("word cycle at odd address");
    chk_write_drive: assert property (bus_cycle |-> data_oe_n == !bus_write)
        else $error("data drive does not follow direction");
    chk_byte_copy: assert property (bus_cycle && bus_write && sz == 2'h1
        |-> data_out[15:8] == data_out[7:0]) else $error("byte not copied to both lanes");
    chk_addr_hold: assert property (bus_cycle && $past(bus_cycle)
        |-> $stable(bus_addr) && $stable(sz) && $stable(data_out))
        else $error("address moved within cycle");
    chk_err_quiet: assert property (rsp_valid && rsp_error |-> !bus_cycle)
        else $error("refused request ran a bus cycle");
    cover property (bus_cycle && sz == 2'h3);
    cover property (rsp_valid && rsp_error);
    cover property ((bus_cycle && ak == 2'h3) [*4]);
endmodule // dbsm_sizer_props

bind dbsm_sizer dbsm_sizer_props #(.AW(AW)) i_dbsm_sizer_props (.clock(clock),
    .reset_n(reset_n), .rsp_valid(rsp_valid), .rsp_error(rsp_error), .bus_cycle(bus_cycle),
    .bus_write(bus_write), .xfer_size_high(xfer_size_high), .xfer_size_low(xfer_size_low),
    .bus_addr(bus_addr), .data_out(data_out), .data_oe_n(data_oe_n),
    .size_ack_high(size_ack_high), .size_ack_low(size_ack_low));

// ==== tb/dbsm_slave_model.sv ====
`timescale 1ns/1ps
module dbsm_slave_model (
    input wire logic clock,
    input wire logic bus_cycle,
    input wire logic bus_write,
    input wire logic [23:0] bus_addr,
    input wire logic port16,
    input wire logic [7:0] delay,
    output logic [15:0] data_in,
    output logic size_ack_high,
    output logic size_ack_low
);
    // ****************************************
    // Memory or peripheral port
    // ****************************************
    logic [7:0] cnt = 8'h00;
    logic [15:0] last_q = 16'h0000;
    logic [7:0] b0, b1;
    initial {size_ack_high, size_ack_low} = 2'h3;
    assign b0 = {bus_addr[7:1], bus_addr[0] & !port16} ^ 8'h5a;
    assign b1 = {bus_addr[7:1], 1'b1} ^ 8'h5a;
    // Idle or unused lanes toggle so a stale value is never seen
    assign data_in = (!bus_cycle || bus_write) ? ~last_q :
        port16 ? {b0, b1} : {b0, ~last_q[7:0]};
    always @(posedge clock) begin
        last_q <= data_in;
        if (!bus_cycle) begin
            cnt <= 8'h00;
            {size_ack_high, size_ack_low} <= 2'h3;
        end else if (cnt < delay) begin
            cnt <= cnt + 8'h01;
        end else begin
            {size_ack_high, size_ack_low} <= port16 ? 2'h1 : 2'h2;
        end
    end
endmodule // dbsm_slave_model

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench;
    // ****************************************
    // Bench
    // ****************************************
    reg clock = 0, reset_n = 0, req_valid = 0, req_write = 0, rsp_ready = 1, port16 = 1, prev = 0;
    reg [1:0] req_size = 2'h0;
    reg [23:0] req_addr = 24'h00_0000;
    reg [31:0] req_wdata = 32'h0000_0000;
    reg [7:0] delay = 8'h02;
    wire req_ready, rsp_valid, rsp_error, bus_cycle, bus_write, sh, sl, data_oe_n, ah, al;
    wire [31:0] rsp_rdata;
    wire [23:0] bus_addr;
    wire [15:0] data_out, data_in;
    integer num_errors = 0, n_tests = 0, cyc = 0;
    logic [41:0] log_q[$];
    logic [15:0] wd[4] = '{16'h1122, 16'h2222, 16'h3344, 16'h4444};
    dbsm_sizer i_dbsm_sizer (.clock(clock), .reset_n(reset_n), .req_valid(req_valid),
        .req_ready(req_ready), .req_write(req_write), .req_size(req_size), .req_addr(req_addr),
        .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
        .rsp_rdata(rsp_rdata), .rsp_error(rsp_error), .bus_cycle(bus_cycle),
        .bus_write(bus_write), .xfer_size_high(sh), .xfer_size_low(sl), .bus_addr(bus_addr),
        .data_out(data_out), .data_oe_n(data_oe_n), .data_in(data_in), .size_ack_high(ah),
        .size_ack_low(al));
    dbsm_slave_model i_dbsm_slave_model (.clock(clock), .bus_cycle(bus_cycle),
        .bus_write(bus_write), .bus_addr(bus_addr), .port16(port16), .delay(delay),
        .data_in(data_in), .size_ack_high(ah), .size_ack_low(al));
    initial forever #5 clock = ~clock;
    always @(posedge clock) begin
        cyc++;
        if (cyc == 50000) begin
            num_errors++;
            finish_test;
        end
    end
    always @(negedge clock) begin
        if (bus_cycle && !prev) log_q.push_back({sh, sl, bus_addr, bus_write ? data_out : 16'h0});
        prev = bus_cycle;
    end
    function [7:0] bb(input [23:0] a);
        bb = a[7:0] ^ 8'h5a;
    endfunction
    task finish_test;
        $display("errors %0d tests %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task cmp_part(input integer i, input [41:0] e);
        n_tests++;
        if (log_q.size() <= i || log_q[i] !== e) begin
            num_errors++;
            $display("mismatch %0t bus part %0d", $time, i);
        end
    endtask
    task cmp_rsp(input e, input [31:0] d, input chk);
        n_tests++;
        if (rsp_valid !== 1'b1 || rsp_error !== e || (chk && rsp_rdata !== d)) begin
            num_errors++;
            $display("mismatch %0t response", $time);
        end
    endtask
    task cmp_cnt(input integer g, input integer e);
        n_tests++;
        if (g != e) begin
            num_errors++;
            $display("mismatch %0t count %0d", $time, g);
        end
    endtask
    task op(input w, input [1:0] s, input [23:0] a, input [31:0] d);
        integer n;
        @(negedge clock);
        log_q.delete();
        {req_write, req_size, req_addr, req_wdata, req_valid} = {w, s, a, d, 1'b1};
        while (req_ready !== 1'b1) @(negedge clock);
        @(negedge clock);
        req_valid = 0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 3000) begin
            @(negedge clock);
            n++;
        end
    endtask
    task t_long16;
        port16 = 1;
        op(1, 2'h0, 24'h00_0100, 32'h1122_3344);
        cmp_rsp(0, 0, 0);
        cmp_part(0, {2'h0, 24'h00_0100, 16'h1122});
        cmp_part(1, {2'h2, 24'h00_0102, 16'h3344});
    endtask
    task t_long8;
        integer i, w;
        {port16, delay} = {1'b0, 8'h03};
        for (w = 0; w < 2; w++) begin
            op(w[0], 2'h0, 24'h00_0200, 32'h1122_3344);
            cmp_rsp(0, {bb(24'h200), bb(24'h201), bb(24'h202), bb(24'h203)}, !w);
            for (i = 0; i < 4; i++)
                cmp_part(i, {2'(4 - i), 24'(24'h00_0200 + i), w ? wd[i] : 16'h0});
        end
    endtask
    task t_byte;
        integer p, a;
        for (p = 0; p < 4; p++) begin
            port16 = p[1];
            a = 24'h00_0300 + p[0];
            op(1, 2'h1, a[23:0], 32'h0000_00a5);
            cmp_rsp(0, 0, 0);
            cmp_part(0, {2'h1, a[23:0], 16'ha5a5});
            op(0, 2'h1, a[23:0], 32'h0000_0000);
            cmp_rsp(0, {24'h0, bb(a[23:0])}, 1);
        end
    endtask
    task t_word;
        {port16, delay} = {1'b1, 8'h00};
        op(0, 2'h2, 24'h00_0500, 32'h0000_0000);
        cmp_rsp(0, {16'h0, bb(24'h500), bb(24'h501)}, 1);
        cmp_part(0, {2'h2, 24'h00_0500, 16'h0});
        op(0, 2'h2, 24'h00_0501, 32'h0000_0000);
        cmp_rsp(1, 0, 0);
        op(1, 2'h0, 24'h00_0503, 32'h0000_0000);
        cmp_rsp(1, 0, 0);
        op(0, 2'h3, 24'h00_0504, 32'h0000_0000);
        cmp_rsp(1, 0, 0);
    endtask
    task t_fifo;
        integer k, m, n;
        delay = 8'h1e;
        @(negedge clock);
        {req_write, req_size, req_addr, req_valid} = {1'b1, 2'h1, 24'h00_0600, 1'b1};
        k = 0;
        while (req_ready === 1'b1 && k < 40) begin
            @(negedge clock);
            k++;
        end
        req_valid = 0;
        // Sixteen queued plus the one the sequencer took
        cmp_cnt(k, 17);
        {m, n} = {32'h0, 32'h0};
        while (m < k && n < 5000) begin
            if (rsp_valid === 1'b1) m++;
            @(negedge clock);
            n++;
        end
        cmp_cnt(m, k);
    endtask
    initial begin
        repeat (8) @(negedge clock);
        reset_n = 1;
        t_long16;
        t_long8;
        t_byte;
        t_word;
        t_fifo;
        finish_test;
    end
endmodule // testbench
